// ===== hdl/sfe_pkg.sv
// constants, types and pin carrier of the serial flash pin front end
// assumes one system clock; the link pins arrive unsynchronised
package sfe_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;

    // control register fields
    localparam int         CTRL_GUARD_EN   = 0;
    localparam int         CTRL_BLOCK_LSB  = 1;
    localparam int         CTRL_REGG_LSB   = 5;
    localparam logic [7:0] CTRL_RESET      = 8'h00;

    // status register fields
    localparam int STAT_SELECTED = 0;
    localparam int STAT_ARMED    = 1;
    localparam int STAT_PAUSED   = 2;
    localparam int STAT_BUSY     = 3;
    localparam int STAT_QUAD_REF = 4;
    localparam int STAT_WR_BLOCK = 5;
    localparam int STAT_QLOCK    = 6;

    // ----------------------------------------------------------------
    // array geometry and framing
    // ----------------------------------------------------------------
    localparam logic [10:0] ARRAY_BLOCKS  = 11'h400;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LANE_SINGLE = 2'h0,
        LANE_DUAL   = 2'h1,
        LANE_QUAD   = 2'h2
    } sfe_lane_type;

    typedef enum logic [2:0] {
        ST_WAIT = 3'h1,
        ST_IDLE = 3'h2,
        ST_SEL  = 3'h4
    } sfe_state_type;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] lane;
    } sfe_pins_type;

endpackage

// ===== hdl/sfe_sync.sv
// two flip-flop synchroniser for a group of unrelated level inputs
// assumes each bit changes slowly against clk
module sfe_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // sfe_sync

// ===== hdl/sfe_pause.sv
// pause tracker driven by the synchronised pause level and link clock
// assumes en is low whenever pausing is not allowed
module sfe_pause (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // conditions
    input  wire logic en,
    input  wire logic hold_n,
    input  wire logic sclk,
    // state
    output logic      paused
);

    // pause level is only taken while the link clock is low, so a change
    // with the clock high waits for the next falling edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            paused <= 1'b0;
        end else if (!en) begin
            paused <= 1'b0;
        end else if (!sclk) begin
            paused <= !hold_n;
        end
    end

endmodule // sfe_pause

// ===== hdl/sfe_front.sv
// serial flash pin front end: select, lanes, pause and write guard
// assumes link pins are asynchronous to clk and clk runs >= 4x sclk
// assumes the core sets lane mode and drive direction per frame phase

// Notes on behaviour
// - deselected means all lanes undriven
// - select low accepts bits and returns data
// - ignore frames until first select fall
// - running internal cycles survive deselect
// - single lane input sampled on rising clock
// - single lane output changes on falling clock
// - dual/quad: sample rising, drive falling
// - lane use per mode; guard/pause only non-quad
// - guard off: pin blocks guard register writes
// - guard on, pin low: all writes rejected
// - guard on refuses quad transfers
// - guard bits select protected block region
// - pause tri-states output, ignores input, clock
// - pause release resumes where stopped
// - quad command disables pause until frame end
// - clock modes zero and three supported
// - pause starts now if clock low
// - pause ends now if clock low
module sfe_front (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    // link pins
    input  wire logic                  sclk_pin,
    input  wire logic                  cs_n_pin,
    input  wire logic [3:0]            lane_in,
    output logic      [3:0]            lane_out,
    output logic      [3:0]            lane_oe,
    // register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // core lane control
    input  wire sfe_pkg::sfe_lane_type core_mode,
    input  wire logic                  core_drive,
    input  wire logic [7:0]            tx_data,
    output logic                       tx_take,
    output logic      [7:0]            rx_data,
    output logic                       rx_valid,
    output logic                       rx_first,
    output logic                       frame_start,
    output logic                       frame_end,
    // core protection
    input  wire logic                  op_busy,
    input  wire logic [9:0]            blk_addr,
    output logic                       blk_locked,
    output logic                       write_block,
    output logic                       reg_write_block
);

    // ----------------------------------------------------------------
    // pin synchronisation and edges
    // ----------------------------------------------------------------
    sfe_pkg::sfe_pins_type pin_raw;
    sfe_pkg::sfe_pins_type pin_s;
    logic                  sclk_q;
    logic                  cs_n_q;
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  cs_fall;
    logic                  cs_rise;

    assign pin_raw.sclk = sclk_pin;
    assign pin_raw.cs_n = cs_n_pin;
    assign pin_raw.lane = lane_in;

    sfe_sync #(
        .W ($bits(sfe_pkg::sfe_pins_type))
    ) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (pin_raw),
        .q    (pin_s)
    );

    // select history starts low so a select held low at reset is no fall
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_q <= 1'b0;
            cs_n_q <= 1'b0;
        end else begin
            sclk_q <= pin_s.sclk;
            cs_n_q <= pin_s.cs_n;
        end
    end

    // edges found either clock idle level: modes zero and three
    assign sclk_rise = pin_s.sclk & ~sclk_q;
    assign sclk_fall = ~pin_s.sclk & sclk_q;
    assign cs_fall   = ~pin_s.cs_n & cs_n_q;
    assign cs_rise   = pin_s.cs_n & ~cs_n_q;

    // ----------------------------------------------------------------
    // control register
    // ----------------------------------------------------------------
    logic [7:0] ctrl;
    logic       guard_en;
    logic [3:0] block_guard_bits;
    logic [1:0] reg_guard_bits;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= sfe_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == sfe_pkg::REG_CTRL) begin
            ctrl <= reg_wdata;
        end
    end

    assign guard_en         = ctrl[sfe_pkg::CTRL_GUARD_EN];
    assign block_guard_bits = ctrl[sfe_pkg::CTRL_BLOCK_LSB +: 4];
    assign reg_guard_bits   = ctrl[sfe_pkg::CTRL_REGG_LSB +: 2];

    // ----------------------------------------------------------------
    // frame state
    // ----------------------------------------------------------------
    sfe_pkg::sfe_state_type state;
    logic                   selected;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= sfe_pkg::ST_WAIT;
        end else begin
            case (state)
                sfe_pkg::ST_WAIT: begin
                    if (cs_fall) begin
                        state <= sfe_pkg::ST_SEL;
                    end
                end
                sfe_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state <= sfe_pkg::ST_SEL;
                    end
                end
                sfe_pkg::ST_SEL: begin
                    // raising select even mid-pause drops the frame
                    if (cs_rise) begin
                        state <= sfe_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= sfe_pkg::ST_WAIT;
                end
            endcase
        end
    end

    assign selected = (state == sfe_pkg::ST_SEL);

    // ----------------------------------------------------------------
    // quad gating and pause
    // ----------------------------------------------------------------
    logic quad_req;
    logic quad_ok;
    logic quad_refused;
    logic quad_lock;
    logic paused;
    logic active;

    assign quad_req     = (core_mode == sfe_pkg::LANE_QUAD);
    assign quad_ok      = quad_req & ~guard_en;
    assign quad_refused = selected & quad_req & guard_en;
    assign active       = selected & ~paused & ~quad_refused;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quad_lock <= 1'b0;
        end else if (!selected || cs_rise) begin
            quad_lock <= 1'b0;
        end else if (quad_ok) begin
            quad_lock <= 1'b1;
        end
    end

    sfe_pause u_pause (
        .clk    (clk),
        .rstn   (rstn),
        .en     (selected & ~quad_lock & ~quad_req),
        .hold_n (pin_s.lane[3]),
        .sclk   (pin_s.sclk),
        .paused (paused)
    );

    // ----------------------------------------------------------------
    // receive shifter
    // ----------------------------------------------------------------
    logic [7:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [7:0] next_rx_sh;
    logic [3:0] next_rx_cnt;
    logic       rx_got_first;

    always_comb begin
        next_rx_sh  = rx_sh;
        next_rx_cnt = rx_cnt;
        case (core_mode)
            sfe_pkg::LANE_DUAL: begin
                next_rx_sh  = {rx_sh[5:0], pin_s.lane[1:0]};
                next_rx_cnt = rx_cnt + 4'h2;
            end
            sfe_pkg::LANE_QUAD: begin
                next_rx_sh  = {rx_sh[3:0], pin_s.lane};
                next_rx_cnt = rx_cnt + 4'h4;
            end
            default: begin
                next_rx_sh  = {rx_sh[6:0], pin_s.lane[0]};
                next_rx_cnt = rx_cnt + 4'h1;
            end
        endcase
    end

    // paused or deselected edges leave the shifter untouched
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_sh        <= 8'h00;
            rx_cnt       <= 4'h0;
            rx_data      <= 8'h00;
            rx_valid     <= 1'b0;
            rx_first     <= 1'b0;
            rx_got_first <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (cs_rise) begin
                rx_cnt       <= 4'h0;
                rx_got_first <= 1'b0;
            end else if (active && sclk_rise && !core_drive) begin
                if (next_rx_cnt >= sfe_pkg::BITS_PER_BYTE) begin
                    rx_data      <= next_rx_sh;
                    rx_valid     <= 1'b1;
                    rx_first     <= ~rx_got_first;
                    rx_got_first <= 1'b1;
                    rx_cnt       <= 4'h0;
                end else begin
                    rx_cnt <= next_rx_cnt;
                end
                rx_sh <= next_rx_sh;
            end
        end
    end

    // ----------------------------------------------------------------
    // transmit shifter
    // ----------------------------------------------------------------
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [7:0] tx_src;
    logic [3:0] tx_step;
    logic [3:0] lane_mask;

    assign tx_src = (tx_cnt == 4'h0) ? tx_data : tx_sh;

    always_comb begin
        tx_step   = 4'h1;
        lane_mask = 4'h2;
        case (core_mode)
            sfe_pkg::LANE_DUAL: begin
                tx_step   = 4'h2;
                lane_mask = 4'h3;
            end
            sfe_pkg::LANE_QUAD: begin
                tx_step   = 4'h4;
                lane_mask = quad_ok ? 4'hf : 4'h0;
            end
            default: begin
                tx_step   = 4'h1;
                lane_mask = 4'h2;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_sh    <= 8'h00;
            tx_cnt   <= 4'h0;
            tx_take  <= 1'b0;
            lane_out <= 4'h0;
        end else begin
            tx_take <= 1'b0;
            if (cs_rise) begin
                tx_cnt <= 4'h0;
            end else if (active && sclk_fall && core_drive) begin
                case (core_mode)
                    sfe_pkg::LANE_DUAL: begin
                        lane_out <= {2'h0, tx_src[7:6]};
                    end
                    sfe_pkg::LANE_QUAD: begin
                        lane_out <= tx_src[7:4];
                    end
                    default: begin
                        lane_out <= {2'h0, tx_src[7], 1'b0};
                    end
                endcase
                tx_sh   <= tx_src << tx_step;
                tx_take <= (tx_cnt == 4'h0);
                tx_cnt  <= ((tx_cnt == 4'h0) ? sfe_pkg::BITS_PER_BYTE : tx_cnt) - tx_step;
            end
        end
    end

    // no lane is driven unless selected, unpaused and in a read phase
    assign lane_oe = (selected && !paused && core_drive) ? lane_mask : 4'h0;

    // ----------------------------------------------------------------
    // write guard and protected region
    // ----------------------------------------------------------------
    logic        wp_low;
    logic [10:0] prot_blocks;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_low <= 1'b0;
        end else if (!quad_req && !quad_lock) begin
            wp_low <= ~pin_s.lane[2];
        end
    end

    // region doubles per step from two blocks up to the whole array
    assign prot_blocks = (block_guard_bits == 4'h0) ? 11'h000 :
                         (block_guard_bits >= 4'ha) ? sfe_pkg::ARRAY_BLOCKS :
                         (11'h001 << block_guard_bits);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            write_block     <= 1'b0;
            reg_write_block <= 1'b0;
            blk_locked      <= 1'b0;
        end else begin
            write_block     <= guard_en & wp_low;
            reg_write_block <= (guard_en & wp_low) |
                               (~guard_en & wp_low & reg_guard_bits[0]);
            blk_locked      <= ({1'b0, blk_addr} < prot_blocks) |
                               (guard_en & wp_low);
        end
    end

    // ----------------------------------------------------------------
    // frame markers and register reads
    // ----------------------------------------------------------------
    logic [7:0] status;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_start <= 1'b0;
            frame_end   <= 1'b0;
        end else begin
            frame_start <= cs_fall && state != sfe_pkg::ST_SEL;
            frame_end   <= cs_rise && selected;
        end
    end

    // busy comes straight from the core; deselect never clears it
    always_comb begin
        status                         = 8'h00;
        status[sfe_pkg::STAT_SELECTED] = selected;
        status[sfe_pkg::STAT_ARMED]    = (state != sfe_pkg::ST_WAIT);
        status[sfe_pkg::STAT_PAUSED]   = paused;
        status[sfe_pkg::STAT_BUSY]     = op_busy;
        status[sfe_pkg::STAT_QUAD_REF] = quad_refused;
        status[sfe_pkg::STAT_WR_BLOCK] = write_block;
        status[sfe_pkg::STAT_QLOCK]    = quad_lock;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reg_addr == sfe_pkg::REG_CTRL) begin
            reg_rdata <= ctrl;
        end else if (reg_rd && reg_addr == sfe_pkg::REG_STATUS) begin
            reg_rdata <= status;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_DESEL_HIZ: assert property (
        @(posedge clk) disable iff (!rstn) !selected |-> lane_oe == 4'h0)
        else $error("lane driven while deselected");
    AST_SEL_ON_FALL: assert property (
        @(posedge clk) disable iff (!rstn) cs_fall |=> selected)
        else $error("select fall did not select");
    AST_NO_ARM_NO_RX: assert property (
        @(posedge clk) disable iff (!rstn) state == sfe_pkg::ST_WAIT |=> !rx_valid)
        else $error("byte taken before first select fall");
    AST_RX_ON_RISE: assert property (
        @(posedge clk) disable iff (!rstn) rx_valid |-> $past(sclk_rise) && $past(active))
        else $error("byte completed without rising clock");
    AST_TX_ON_FALL: assert property (
        @(posedge clk) disable iff (!rstn) $changed(lane_out) |-> $past(sclk_fall))
        else $error("output lane changed off falling clock");
    AST_QUAD_LANES: assert property (
        @(posedge clk) disable iff (!rstn) lane_oe[3] |-> quad_ok && selected)
        else $error("lane three driven outside quad");
    AST_HW_BLOCK: assert property (
        @(posedge clk) disable iff (!rstn) guard_en && wp_low |=> write_block && blk_locked)
        else $error("write not blocked by guard pin");
    AST_QUAD_REFUSE: assert property (
        @(posedge clk) disable iff (!rstn) guard_en |-> !lane_oe[2] && !lane_oe[3])
        else $error("quad drive while guard enabled");
    AST_PAUSE_HIZ: assert property (
        @(posedge clk) disable iff (!rstn) paused |-> lane_oe == 4'h0)
        else $error("lane driven while paused");
    AST_PAUSE_FROZEN: assert property (
        @(posedge clk) disable iff (!rstn) paused && !cs_rise |=> $stable(rx_cnt) && !rx_valid)
        else $error("shifter moved while paused");
    AST_QUAD_NO_PAUSE: assert property (
        @(posedge clk) disable iff (!rstn) quad_lock |=> !paused)
        else $error("pause active during quad frame");
    AST_FRAME_CLEAR: assert property (
        @(posedge clk) disable iff (!rstn) cs_rise && selected |=> rx_cnt == 4'h0 && !selected
            ##1 frame_end == 1'b0)
        else $error("frame state survived select rise");

    COV_BYTE_RX: cover property (@(posedge clk) disable iff (!rstn) rx_valid && rx_first);
    COV_PAUSE: cover property (@(posedge clk) disable iff (!rstn) $rose(paused) ##[1:400] $fell(paused));
    COV_QUAD_TX: cover property (@(posedge clk) disable iff (!rstn) tx_take && quad_ok);
    COV_BLOCKED: cover property (@(posedge clk) disable iff (!rstn) $rose(write_block));

endmodule // sfe_front

// ===== verification/sfe_host.sv
// host model: drives link clock, select, lanes 0/1 and the wp/pause pins
// assumes a 200 ns link period; lane1 read late in the high phase
module sfe_host (
    output logic            sclk,
    output logic            cs_n,
    output logic [3:0]      lane,
    input  wire logic [3:0] pin,
    input  wire logic       wp_n,
    input  wire logic       pause_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       m3 = 1'b0;
    logic [1:0] d = 2'h0;
    assign lane = {pause_n, wp_n, d};
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    task sel(input logic mode3);
        m3 = mode3;
        sclk = mode3;
        #100 cs_n = 1'b0;
        #200;
    endtask
    // select rises only after the clock is back at idle
    task desel();
        #100 cs_n = 1'b1;
        #300;
    endtask
    // released lane1 toggles so a stale value cannot pass
    task shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            d = {~d[1], tx[i]};
            #100 sclk = 1'b1;
            #99 rx[i] = pin[1];
            #1;
        end
        sclk = m3;
        #100;
    endtask
endmodule // sfe_host

// ===== verification/testbench.sv
// self-checking bench of sfe_front with a host model on the link pins
// assumes 40 MHz clk; lane pin level resolved from device enables
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rstn, reg_wr, reg_rd, core_drive, op_busy, wp_n, pause_n;
    logic       rx_valid, rx_first, rx_fst, blk_locked, write_block, reg_write_block;
    logic       sclk, cs_n;
    logic [3:0] reg_addr, lane_out, lane_oe, lane_in, hl;
    logic [7:0] reg_wdata, reg_rdata, tx_data, rx_data, seed, got, rx_seen;
    logic [9:0] blk_addr;
    int         err_total, cmp_count, n;
    int         rx_cnt = 0;
    sfe_pkg::sfe_lane_type core_mode;
    assign lane_in = (lane_oe & lane_out) | (~lane_oe & hl);
    sfe_front sfe_front_i (.clk(clk), .rstn(rstn), .sclk_pin(sclk), .cs_n_pin(cs_n),
        .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_mode(core_mode), .core_drive(core_drive), .tx_data(tx_data), .tx_take(),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_first(rx_first), .frame_start(),
        .frame_end(), .op_busy(op_busy), .blk_addr(blk_addr), .blk_locked(blk_locked),
        .write_block(write_block), .reg_write_block(reg_write_block));
    sfe_host sfe_host_i (.sclk(sclk), .cs_n(cs_n), .lane(hl), .pin(lane_in),
        .wp_n(wp_n), .pause_n(pause_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // protected block count for a block guard setting
    function automatic logic [10:0] prot(input logic [3:0] b);
        return (b == 4'h0) ? 11'h000 : (b >= 4'ha) ? 11'h400 : 11'h001 << b;
    endfunction
    // lane1 bits seen over eight falls, w lanes wide, constant byte s
    function automatic logic [7:0] lane1_seq(input logic [7:0] s, input int w);
        for (int i = 0; i < 8; i++) begin
            lane1_seq[7 - i] = s[9 - w * (i % (8 / w) + 1)];
        end
    endfunction
    task check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task print_verdict();
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask
    task link_byte(input logic m3, input logic [7:0] tx, output logic [7:0] rx);
        sfe_host_i.sel(m3);
        sfe_host_i.shift(tx, rx);
        sfe_host_i.desel();
    endtask
    always @(posedge clk) begin
        if (rx_valid === 1'b1) begin
            rx_seen <= rx_data;
            rx_fst <= rx_first;
            rx_cnt <= rx_cnt + 1;
        end
    end
    initial begin
        #2000000;
        err_total++;
        print_verdict();
    end
    initial begin
        {rstn, reg_wr, reg_rd, core_drive, op_busy, reg_addr, reg_wdata} = '0;
        {tx_data, blk_addr, err_total, cmp_count} = '0;
        core_mode = sfe_pkg::LANE_SINGLE;
        {wp_n, pause_n} = 2'h3;
        seed = 8'h22;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(sfe_pkg::REG_CTRL, got);
        check("ctrl reset", got, sfe_pkg::CTRL_RESET);
        rd(4'h8, got);
        check("unmapped", got, 8'h00);
        rd(sfe_pkg::REG_STATUS, got);
        check("unarmed", got, 8'h00);
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            link_byte(k[0], seed, got);
            check("rx byte", {rx_fst, rx_seen}, {1'b1, seed});
            check("oe idle", lane_oe, 4'h0);
        end
        sfe_host_i.sel(1'b0);
        for (int k = 0; k < 2; k++) begin
            seed = lfsr(seed);
            sfe_host_i.shift(seed, got);
            check("rx pair", {rx_fst, rx_seen}, {~k[0], seed});
        end
        sfe_host_i.desel();
        check("rx count", rx_cnt, 6);
        seed = lfsr(seed);
        @(posedge clk);
        core_drive <= 1'b1;
        tx_data <= seed;
        link_byte(1'b1, 8'h00, got);
        check("tx byte", got, seed);
        check("oe desel", lane_oe, 4'h0);
        sfe_host_i.sel(1'b0);
        @(posedge clk);
        pause_n <= 1'b0;
        repeat (10) @(posedge clk);
        rd(sfe_pkg::REG_STATUS, got);
        check("paused", got[sfe_pkg::STAT_PAUSED], 1'b1);
        check("oe paused", lane_oe[1], 1'b0);
        pause_n <= 1'b1;
        repeat (10) @(posedge clk);
        rd(sfe_pkg::REG_STATUS, got);
        check("unpaused", got[sfe_pkg::STAT_PAUSED], 1'b0);
        check("oe resumed", lane_oe[1], 1'b1);
        sfe_host_i.desel();
        // dual then quad read-out; the quad frame then tries to pause
        for (int q = 1; q < 3; q++) begin
            core_mode <= sfe_pkg::sfe_lane_type'(q);
            sfe_host_i.sel(1'b1);
            sfe_host_i.shift(8'h00, got);
            check("lane1 seq", got, lane1_seq(seed, 2 * q));
            check("oe wide", lane_oe, (q == 2) ? 11'h00f : 11'h003);
            if (q == 2) begin
                core_drive <= 1'b0;
                core_mode <= sfe_pkg::LANE_SINGLE;
                sfe_host_i.sel(1'b0);
                @(posedge clk);
                pause_n <= 1'b0;
                repeat (10) @(posedge clk);
                rd(sfe_pkg::REG_STATUS, got);
                n = {got[sfe_pkg::STAT_QLOCK], got[sfe_pkg::STAT_PAUSED]};
                check("quad lock", n, 11'h002);
                pause_n <= 1'b1;
            end
            sfe_host_i.desel();
        end
        wr(sfe_pkg::REG_CTRL, 8'h01);
        wp_n <= 1'b0;
        repeat (8) @(posedge clk);
        check("hw block", write_block, 1'b1);
        check("hw reg block", reg_write_block, 1'b1);
        wr(sfe_pkg::REG_CTRL, 8'h20);
        repeat (8) @(posedge clk);
        check("sw block", write_block, 1'b0);
        check("sw reg block", reg_write_block, 1'b1);
        wp_n <= 1'b1;
        repeat (8) @(posedge clk);
        check("sw reg free", reg_write_block, 1'b0);
        for (int b = 0; b < 11; b++) begin
            wr(sfe_pkg::REG_CTRL, {3'h0, b[3:0], 1'b0});
            rd(sfe_pkg::REG_CTRL, got);
            check("ctrl rd", got, {3'h0, b[3:0], 1'b0});
            for (int e = -1; e < 1; e++) begin
                blk_addr <= 10'(prot(b[3:0]) + 11'(e));
                repeat (3) @(posedge clk);
                check("locked", blk_locked, {10'h0, 11'(blk_addr) < prot(b[3:0])});
            end
        end
        wr(sfe_pkg::REG_CTRL, 8'h01);
        core_mode <= sfe_pkg::LANE_QUAD;
        n = rx_cnt;
        sfe_host_i.sel(1'b0);
        sfe_host_i.shift(seed, got);
        rd(sfe_pkg::REG_STATUS, got);
        check("quad refused", got[sfe_pkg::STAT_QUAD_REF], 1'b1);
        op_busy <= 1'b1;
        sfe_host_i.desel();
        check("quad no rx", rx_cnt, n);
        core_mode <= sfe_pkg::LANE_SINGLE;
        rd(sfe_pkg::REG_STATUS, got);
        check("busy", got[sfe_pkg::STAT_BUSY], 1'b1);
        print_verdict();
    end
endmodule // testbench
